// [modulo_address_pkg.sv]
// Constants shared by the modulo address update datapath
package modulo_address_pkg;

	// ----------------------------------------
	// Register map (APB byte addresses)
	// ----------------------------------------
	localparam logic [11:0] ADDR_MODIFIER = 12'h000;
	localparam logic [11:0] ADDR_POINTER_ZERO = 12'h004;
	localparam logic [11:0] ADDR_POINTER_ONE = 12'h008;
	localparam logic [11:0] ADDR_POINTER_TWO = 12'h00C;
	localparam logic [11:0] ADDR_POINTER_THREE = 12'h010;
	localparam logic [11:0] ADDR_STACK_POINTER = 12'h014;
	localparam logic [11:0] ADDR_STATUS = 12'h018;

	// ----------------------------------------
	// Modifier fields and reset
	// ----------------------------------------
	localparam logic [15:0] MODIFIER_RESET = 16'hFFFF;
	localparam int MODE_MSB = 15;
	localparam int MODE_LSB = 14;
	localparam int LENGTH_MSB = 13;
	localparam logic [1:0] MODE_ZERO_ONLY = 2'h0;
	localparam logic [1:0] MODE_BOTH = 2'h2;
	localparam logic [1:0] MODE_LINEAR = 2'h3;
	localparam logic [15:0] POINTER_RESET = 16'h0000;

	// ----------------------------------------
	// Pointer selects and update kinds
	// ----------------------------------------
	localparam logic [2:0] SEL_ZERO = 3'h0;
	localparam logic [2:0] SEL_ONE = 3'h1;
	localparam logic [2:0] SEL_TWO = 3'h2;
	localparam logic [2:0] SEL_THREE = 3'h3;
	localparam logic [2:0] SEL_STACK = 3'h4;

	typedef enum logic [2:0] {
		UPD_NONE = 3'h0,
		UPD_INC = 3'h1,
		UPD_DEC = 3'h2,
		UPD_OFFSET = 3'h3,
		UPD_INDEX_OFFSET = 3'h4,
		UPD_INDEX_LONG = 3'h5
	} update_kind_t;

endpackage : modulo_address_pkg

// [modulo_calc.sv]
// Combinational modulo or linear pointer arithmetic
`timescale 1ns/100ps
module modulo_calc #(
	parameter int WIDTH = 16,
	parameter int LEN_WIDTH = 14
) (
	// Operands
	input wire logic [WIDTH-1:0] pointer,
	input wire logic [WIDTH-1:0] offset,
	input wire logic [LEN_WIDTH-1:0] length_m1,
	input wire logic use_modulo,
	// Result
	output logic [WIDTH-1:0] result
);
	initial
	begin
		if (LEN_WIDTH >= WIDTH || LEN_WIDTH < 1)
			$error("modulo_calc: LEN_WIDTH must be below WIDTH");
	end

	logic [WIDTH-1:0] mask;
	logic [WIDTH-1:0] low_sum;
	logic [WIDTH-1:0] base;
	logic [WIDTH:0] modulus;
	logic [WIDTH+1:0] reduced;

	always_comb
	begin
		mask = '0;
		for (int b = 0; b < LEN_WIDTH; b++)
			if (length_m1 >= (LEN_WIDTH'(1) << b))
				mask[b] = 1'b1;
		mask[0] = 1'b1;
		base = pointer & ~mask;
		modulus = {{(WIDTH+1-LEN_WIDTH){1'b0}}, length_m1} + (WIDTH+1)'(1);
		low_sum = (pointer & mask) + offset;
		// Signed reduce, offset magnitude at most the modulus assumed
		reduced = {{2{1'b0}}, low_sum & mask};
		if (offset[WIDTH-1])
		begin
			reduced = {{2{1'b0}}, low_sum & mask};
			if ({1'b0, (pointer & mask)} < {1'b0, -offset})
				reduced = (WIDTH+2)'({1'b0, pointer & mask}) +
					(WIDTH+2)'(modulus) - (WIDTH+2)'({1'b0, -offset});
		end
		else
		begin
			// Step past top wraps to base
			if ((WIDTH+2)'({1'b0, pointer & mask}) + (WIDTH+2)'(offset)
				>= (WIDTH+2)'(modulus))
				reduced = (WIDTH+2)'({1'b0, pointer & mask}) +
					(WIDTH+2)'(offset) - (WIDTH+2)'(modulus);
		end
		// Upper bits held; result below modulus
		if (use_modulo)
			result = base | (reduced[WIDTH-1:0] & mask);
		else
			result = pointer + offset;
	end
endmodule : modulo_calc

// [modulo_address_update.sv]
// Address-update datapath with modulo and linear pointer arithmetic
`timescale 1ns/100ps
module modulo_address_update #(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Update request from the instruction decoder
	input wire logic upd_valid,
	input wire logic [2:0] upd_pointer,
	input wire logic [2:0] upd_kind,
	input wire logic [WIDTH-1:0] upd_offset,
	// Address to data memory
	output logic [WIDTH-1:0] mem_address,
	output logic mem_address_valid
);
	initial
	begin
		if (WIDTH != 16)
			$error("modulo_address_update: WIDTH must be 16");
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [15:0] address_modifier;
	logic [WIDTH-1:0] pointer_zero;
	logic [WIDTH-1:0] pointer_one;
	logic [WIDTH-1:0] pointer_two;
	logic [WIDTH-1:0] pointer_three;
	logic [WIDTH-1:0] stack_pointer;
	logic [7:0] update_count;

	logic apb_write;
	logic apb_read;
	logic decode_hit;
	logic [WIDTH-1:0] cur_pointer;
	logic [WIDTH-1:0] step;
	logic [WIDTH-1:0] next_pointer;
	logic [WIDTH-1:0] access_address;
	logic use_modulo;
	logic writes_back;
	logic [1:0] mode;

	assign apb_write = psel && penable && pwrite;
	assign apb_read = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign mode = address_modifier[modulo_address_pkg::MODE_MSB:modulo_address_pkg::MODE_LSB];

	// ----------------------------------------
	// Operand selection
	// ----------------------------------------
	always_comb
	begin
		unique case (upd_pointer)
			modulo_address_pkg::SEL_ZERO: cur_pointer = pointer_zero;
			modulo_address_pkg::SEL_ONE: cur_pointer = pointer_one;
			modulo_address_pkg::SEL_TWO: cur_pointer = pointer_two;
			modulo_address_pkg::SEL_THREE: cur_pointer = pointer_three;
			default: cur_pointer = stack_pointer;
		endcase
	end

	always_comb
	begin
		step = '0;
		writes_back = 1'b0;
		unique case (modulo_address_pkg::update_kind_t'(upd_kind))
			modulo_address_pkg::UPD_INC:
			begin
				step = WIDTH'(1);
				writes_back = 1'b1;
			end
			modulo_address_pkg::UPD_DEC:
			begin
				step = '1;
				writes_back = 1'b1;
			end
			modulo_address_pkg::UPD_OFFSET:
			begin
				step = upd_offset;
				writes_back = 1'b1;
			end
			modulo_address_pkg::UPD_INDEX_OFFSET,
			modulo_address_pkg::UPD_INDEX_LONG:
				step = upd_offset;
			default:
				step = '0;
		endcase
	end

	always_comb
	begin
		// One modifier; mode from top bits
		// Shared length; pattern 11 is linear
		unique case (upd_pointer)
			modulo_address_pkg::SEL_ZERO:
				use_modulo = (mode == modulo_address_pkg::MODE_ZERO_ONLY) ||
					(mode == modulo_address_pkg::MODE_BOTH);
			modulo_address_pkg::SEL_ONE:
				use_modulo = (mode == modulo_address_pkg::MODE_BOTH);
			default:
				use_modulo = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Arithmetic
	// ----------------------------------------
	// Modulus from low fourteen bits; used in modes 00 and 10 only
	modulo_calc #(
		.WIDTH(WIDTH),
		.LEN_WIDTH(modulo_address_pkg::LENGTH_MSB + 1)
	) u_calc (
		.pointer(cur_pointer),
		.offset(step),
		.length_m1(address_modifier[modulo_address_pkg::LENGTH_MSB:0]),
		.use_modulo(use_modulo),
		.result(next_pointer)
	);

	// Indexed modes address at the computed value, others at the old pointer
	assign access_address = writes_back ? cur_pointer :
		(upd_kind == 3'(modulo_address_pkg::UPD_NONE) ? cur_pointer : next_pointer);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mem_address <= '0;
			mem_address_valid <= 1'b0;
		end
		else
		begin
			mem_address <= upd_valid ? access_address : mem_address;
			mem_address_valid <= upd_valid;
		end
	end

	// ----------------------------------------
	// Modifier register
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			address_modifier <= modulo_address_pkg::MODIFIER_RESET;
		else if (apb_write && paddr == modulo_address_pkg::ADDR_MODIFIER)
		begin
			if (pstrb[0])
				address_modifier[7:0] <= pwdata[7:0];
			if (pstrb[1])
				address_modifier[15:8] <= pwdata[15:8];
		end
	end

	// ----------------------------------------
	// Pointer registers
	// ----------------------------------------
	function automatic logic [WIDTH-1:0] merge(input logic [WIDTH-1:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [WIDTH-1:0] r;
		r = old;
		if (strb[0])
			r[7:0] = data[7:0];
		if (strb[1])
			r[15:8] = data[15:8];
		return r;
	endfunction : merge

	function automatic logic hit(input logic [2:0] sel, input logic [2:0] idx);
		return upd_valid && writes_back && sel == idx;
	endfunction : hit

	// Write back on the access edge; calculator result used, modulo or linear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pointer_zero <= modulo_address_pkg::POINTER_RESET;
			pointer_one <= modulo_address_pkg::POINTER_RESET;
			pointer_two <= modulo_address_pkg::POINTER_RESET;
			pointer_three <= modulo_address_pkg::POINTER_RESET;
			stack_pointer <= modulo_address_pkg::POINTER_RESET;
		end
		else
		begin
			// Core update wins over a software write in the same cycle
			if (hit(upd_pointer, modulo_address_pkg::SEL_ZERO))
				pointer_zero <= next_pointer;
			else if (apb_write && paddr == modulo_address_pkg::ADDR_POINTER_ZERO)
				pointer_zero <= merge(pointer_zero, pwdata, pstrb);
			if (hit(upd_pointer, modulo_address_pkg::SEL_ONE))
				pointer_one <= next_pointer;
			else if (apb_write && paddr == modulo_address_pkg::ADDR_POINTER_ONE)
				pointer_one <= merge(pointer_one, pwdata, pstrb);
			if (hit(upd_pointer, modulo_address_pkg::SEL_TWO))
				pointer_two <= next_pointer;
			else if (apb_write && paddr == modulo_address_pkg::ADDR_POINTER_TWO)
				pointer_two <= merge(pointer_two, pwdata, pstrb);
			if (hit(upd_pointer, modulo_address_pkg::SEL_THREE))
				pointer_three <= next_pointer;
			else if (apb_write && paddr == modulo_address_pkg::ADDR_POINTER_THREE)
				pointer_three <= merge(pointer_three, pwdata, pstrb);
			if (upd_valid && writes_back && upd_pointer >= modulo_address_pkg::SEL_STACK)
				stack_pointer <= next_pointer;
			else if (apb_write && paddr == modulo_address_pkg::ADDR_STACK_POINTER)
				stack_pointer <= merge(stack_pointer, pwdata, pstrb);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			update_count <= 8'h00;
		else if (upd_valid && writes_back)
			update_count <= update_count + 8'h01;
	end

	// ----------------------------------------
	// APB read path
	// ----------------------------------------
	always_comb
	begin
		decode_hit = 1'b1;
		unique case (paddr)
			modulo_address_pkg::ADDR_MODIFIER,
			modulo_address_pkg::ADDR_POINTER_ZERO,
			modulo_address_pkg::ADDR_POINTER_ONE,
			modulo_address_pkg::ADDR_POINTER_TWO,
			modulo_address_pkg::ADDR_POINTER_THREE,
			modulo_address_pkg::ADDR_STACK_POINTER,
			modulo_address_pkg::ADDR_STATUS: decode_hit = 1'b1;
			default: decode_hit = 1'b0;
		endcase
	end

	assign pslverr = psel && penable && !decode_hit;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
		begin
			unique case (paddr)
				modulo_address_pkg::ADDR_MODIFIER: prdata <= {16'h0000, address_modifier};
				modulo_address_pkg::ADDR_POINTER_ZERO: prdata <= {16'h0000, pointer_zero};
				modulo_address_pkg::ADDR_POINTER_ONE: prdata <= {16'h0000, pointer_one};
				modulo_address_pkg::ADDR_POINTER_TWO: prdata <= {16'h0000, pointer_two};
				modulo_address_pkg::ADDR_POINTER_THREE: prdata <= {16'h0000, pointer_three};
				modulo_address_pkg::ADDR_STACK_POINTER: prdata <= {16'h0000, stack_pointer};
				modulo_address_pkg::ADDR_STATUS: prdata <= {20'h00000, update_count, 2'h0, mode};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule : modulo_address_update

// [modulo_address_update_monitor.sv]
// Checker of update timing, modifier reads and linear steps
`timescale 1ns/100ps
module modulo_address_update_monitor #(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Update port
	input wire logic upd_valid,
	input wire logic [2:0] upd_pointer,
	input wire logic [2:0] upd_kind,
	input wire logic [WIDTH-1:0] upd_offset,
	input wire logic [WIDTH-1:0] mem_address,
	input wire logic mem_address_valid
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [15:0] modifier;
	wire acc = psel && penable;
	wire inc = upd_valid && upd_kind == 3'h1;
	// Shadow copy, so reads of the modifier can be judged
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			modifier <= 16'hFFFF;
		else if (acc && pwrite && paddr == 12'h000)
		begin
			if (pstrb[0])
				modifier[7:0] <= pwdata[7:0];
			if (pstrb[1])
				modifier[15:8] <= pwdata[15:8];
		end
	end
	property step(en, d);
		en [*2] |=> mem_address == $past(mem_address) + d;
	endproperty
	valid_follows_a: assert property (upd_valid |=> mem_address_valid)
		else $error("address valid missing");
	valid_quiet_a: assert property (!upd_valid |=> !mem_address_valid)
		else $error("address valid without update");
	modifier_read_a: assert property (acc && !pwrite && paddr == 12'h000 |-> prdata == {16'h0000, modifier})
		else $error("modifier read wrong");
	unmapped_err_a: assert property (acc && paddr > 12'h018 |-> pslverr)
		else $error("unmapped access accepted");
	mapped_ok_a: assert property (acc && paddr[1:0] == 2'h0 && paddr <= 12'h018 |-> !pslverr)
		else $error("mapped access refused");
	linear_inc_a: assert property (step(inc && upd_pointer == 3'h2, 16'h0001))
		else $error("pointer two step wrong");
	stack_dec_a: assert property (step(upd_valid && upd_pointer == 3'h4 && upd_kind == 3'h2, 16'hFFFF))
		else $error("stack step wrong");
	zero_linear_a: assert property (step(inc && upd_pointer == 3'h0 && modifier == 16'hFFFF, 16'h0001))
		else $error("pointer zero not linear");
	one_linear_a: assert property (step(inc && upd_pointer == 3'h1 && modifier[15:14] == 2'h0, 16'h0001))
		else $error("pointer one not linear");
	cover property (upd_valid && upd_kind == 3'h3);
	cover property (acc && pslverr);
	cover property (inc && modifier[15:14] == 2'h2);
endmodule : modulo_address_update_monitor
bind modulo_address_update modulo_address_update_monitor #(.WIDTH(WIDTH)) modulo_address_update_monitor_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .upd_valid(upd_valid), .upd_pointer(upd_pointer), .upd_kind(upd_kind),
	.upd_offset(upd_offset), .mem_address(mem_address), .mem_address_valid(mem_address_valid));

// [decoder_model.sv]
// Instruction decoder stand-in for the pointer update port
`timescale 1ns/100ps
module decoder_model (
	// Clock
	input wire logic pclk,
	// Update request
	output logic upd_valid,
	output logic [2:0] upd_pointer,
	output logic [2:0] upd_kind,
	output logic [15:0] upd_offset,
	// Address returned
	input wire logic [15:0] mem_address,
	input wire logic mem_address_valid
);
	logic [15:0] seen [$];
	initial
	begin
		upd_valid = 1'h0;
		upd_pointer = 3'h0;
		upd_kind = 3'h0;
		upd_offset = 16'h0000;
	end
	always @(posedge pclk)
	begin
		if (mem_address_valid === 1'h1)
			seen.push_back(mem_address);
	end
	// Back-to-back updates; idle kind and offset are inverted so stale values never help
	task burst(input logic [2:0] sel, input logic [2:0] kind, input logic [15:0] off, input int n);
		repeat (n)
		begin
			@(posedge pclk);
			upd_valid <= 1'h1;
			upd_pointer <= sel;
			upd_kind <= kind;
			upd_offset <= off;
		end
		@(posedge pclk);
		upd_valid <= 1'h0;
		upd_offset <= ~off;
		upd_kind <= ~kind;
		@(posedge pclk);
		#1;
	endtask : burst
endmodule : decoder_model

// [modulo_address_update_test.sv]
// Self-checking bench for the modulo address update datapath
`timescale 1ns/100ps
module modulo_address_update_test;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, upd_valid, mem_address_valid;
	logic [2:0] upd_pointer, upd_kind;
	logic [15:0] upd_offset, mem_address;
	logic [15:0] modifier = 16'hFFFF;
	logic [15:0] ptr [0:4] = '{default: 16'h0000};
	int failures = 0;
	int checked = 0;
	int updates = 0;
	always #2.5 pclk = ~pclk;
	modulo_address_update modulo_address_update_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .upd_valid(upd_valid),
		.upd_pointer(upd_pointer), .upd_kind(upd_kind), .upd_offset(upd_offset),
		.mem_address(mem_address), .mem_address_valid(mem_address_valid));
	decoder_model decoder_model_i (.pclk(pclk), .upd_valid(upd_valid), .upd_pointer(upd_pointer),
		.upd_kind(upd_kind), .upd_offset(upd_offset), .mem_address(mem_address),
		.mem_address_valid(mem_address_valid));
	task give_verdict;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : give_verdict
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task apb(input logic wr, input logic [11:0] a, input logic [15:0] d, input logic [31:0] exp);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1)
			@(posedge pclk);
		if (!wr)
			chk(prdata, exp);
		chk({31'h0, pslverr}, {31'h0, a > 12'h018});
		psel <= 1'h0;
		penable <= 1'h0;
		if (wr && a == 12'h000)
			modifier = d;
		else if (wr)
			ptr[a[4:2] - 3'h1] = d;
	endtask : apb
	function automatic logic [15:0] nxt(input logic [15:0] p, input logic [15:0] off, input logic md);
		int len;
		int k;
		int low;
		logic [15:0] mask;
		len = modifier[13:0] + 1;
		k = 0;
		if (!md)
			return p + off;
		while ((1 << k) < len)
			k++;
		mask = (16'h0001 << k) - 16'h0001;
		low = (int'(p & mask) + int'($signed(off))) % len;
		if (low < 0)
			low += len;
		return (p & ~mask) | 16'(low);
	endfunction : nxt
	task run(input logic [2:0] sel, input logic [2:0] kind, input logic [15:0] off, input int n);
		logic md;
		logic [15:0] stp;
		md = (sel == 3'h0 && modifier[15:14] != 2'h3) || (sel == 3'h1 && modifier[15:14] == 2'h2);
		stp = kind == 3'h1 ? 16'h0001 : kind == 3'h2 ? 16'hFFFF : off;
		decoder_model_i.seen.delete();
		decoder_model_i.burst(sel, kind, off, n);
		if (kind > 3'h0 && kind < 3'h4)
			updates += n;
		chk(decoder_model_i.seen.size(), n);
		foreach (decoder_model_i.seen[i])
		begin
			chk(decoder_model_i.seen[i], kind > 3'h3 ? nxt(ptr[sel], off, md) : ptr[sel]);
			if (kind > 3'h0 && kind < 3'h4)
				ptr[sel] = nxt(ptr[sel], stp, md);
		end
		apb(1'h0, {7'h00, sel + 3'h1, 2'h0}, 16'h0000, {16'h0000, ptr[sel]});
	endtask : run
	task reset_values;
		apb(1'h0, 12'h000, 16'h0000, 32'h0000FFFF);
		apb(1'h0, 12'h004, 16'h0000, 32'h00000000);
		apb(1'h0, 12'h01C, 16'h0000, 32'h00000000);
		$display("reset_values done");
	endtask : reset_values
	task zero_only;
		apb(1'h1, 12'h000, 16'h0004, 32'h0);
		apb(1'h1, 12'h004, 16'h0802, 32'h0);
		apb(1'h1, 12'h008, 16'h0802, 32'h0);
		run(3'h0, 3'h1, 16'h0000, 7);
		run(3'h0, 3'h2, 16'h0000, 7);
		run(3'h0, 3'h3, 16'h0003, 6);
		run(3'h0, 3'h3, 16'hFFFD, 6);
		run(3'h1, 3'h1, 16'h0000, 4);
		run(3'h0, 3'h4, 16'h0003, 2);
		run(3'h0, 3'h5, 16'hFFFE, 2);
		run(3'h0, 3'h0, 16'h0000, 2);
		$display("zero_only done");
	endtask : zero_only
	task both_pointers;
		apb(1'h1, 12'h000, 16'h8024, 32'h0);
		apb(1'h1, 12'h004, 16'h0090, 32'h0);
		apb(1'h1, 12'h008, 16'h1FA0, 32'h0);
		run(3'h0, 3'h3, 16'h0011, 5);
		run(3'h1, 3'h1, 16'h0000, 40);
		run(3'h2, 3'h1, 16'h0000, 3);
		run(3'h4, 3'h2, 16'h0000, 3);
		run(3'h3, 3'h3, 16'h8000, 2);
		$display("both_pointers done");
	endtask : both_pointers
	task linear_modes;
		apb(1'h1, 12'h000, 16'h3FFF, 32'h0);
		apb(1'h1, 12'h004, 16'h4000, 32'h0);
		run(3'h0, 3'h2, 16'h0000, 2);
		apb(1'h1, 12'h000, 16'hFFFF, 32'h0);
		apb(1'h1, 12'h004, 16'hFFFE, 32'h0);
		run(3'h0, 3'h1, 16'h0000, 3);
		run(3'h1, 3'h3, 16'hFFF0, 2);
		// Status: write-back count in bits 11:4, mode in bits 1:0
		apb(1'h0, 12'h018, 16'h0000, {20'h00000, updates[7:0], 2'h0, modifier[15:14]});
		$display("linear_modes done");
	endtask : linear_modes
	initial
	begin
		#20000;
		failures++;
		give_verdict();
	end
	initial
	begin
		repeat (5)
			@(posedge pclk);
		presetn <= 1'h1;
		reset_values();
		zero_only();
		both_pointers();
		linear_modes();
		give_verdict();
	end
endmodule : modulo_address_update_test
